// ===== fbr_burst_read.sv
// synchronous burst read engine and its configuration word
//
// How it works
// R01: continuous burst runs on, wrapping at top, until abort or new address.
// R02: entering an idle bank may add empty edges; host watches ready.
// R03: entering a busy bank halts burst, ready off, data still driven.
// R04: wrap reads stay in the aligned 8- or 16-word group.
// R05: wrap starts at latched word, steps, wraps, gives at most group words.
// R06: 8-word wrap delivers on consecutive edges with no waits.
// R07: last wrap word is held until abort or new address.
// R08: 16-word wrap may add waits at the half crossing; none added here.
// R09: wrap modes never insert 128-word crossing waits.
// R10: hardware reset restores config defaults; command reset keeps config.
// R11: host should write the config word before bursting.
// R12: config word can be read back.
// R13: wait code 1 to 11 gives data on edge 3 to 13 after latch.
// R14: config bit 10 sets ready polarity, high by default.
// R15: config bit 8: 0 ready one edge early, 1 ready with data.
// R16: config bit 7 selects full or half output drive.
// R17: length code 3 is 16-word wrap, default continuous.
// R18: config bit 15 selects burst reads when 0, async by default.
// R19: after latency, one word per edge and the address steps.
// R20: length code 2 is 8-word wrap, other codes reserved.
`timescale 1ns/10ps
module fbr_burst_read (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // link pins
    input  wire logic                       bus_clk,
    input  wire logic                       ce_n,
    input  wire logic                       address_latch_strobe_n,
    input  wire logic [fbr_pkg::HI_W-1:0]   addr_hi,
    input  wire logic [fbr_pkg::DATA_W-1:0] adq_in,
    output logic      [fbr_pkg::DATA_W-1:0] adq_out,
    output logic                            adq_oe,
    output logic                            rdy,
    output logic                            half_drive,
    // command decoder side
    input  wire logic                       cfg_wr_en,
    input  wire logic [fbr_pkg::CFG_W-1:0]  cfg_wr_data,
    input  wire logic                       cmd_reset,
    output logic      [fbr_pkg::CFG_W-1:0]  cfg_rd_data,
    // array side
    output logic      [fbr_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [fbr_pkg::DATA_W-1:0] mem_rdata,
    input  wire logic [fbr_pkg::NUM_BANKS-1:0] bank_busy
);
    fbr_pins_if pins ();

    logic [fbr_pkg::CFG_W-1:0]  cfg_d,  cfg_q;
    logic                       drive_d, drive_q;
    fbr_pkg::fbr_state_type     state_d, state_q;
    fbr_pkg::fbr_mode_type      mode_d, mode_q;
    logic [3:0]                 cnt_d,  cnt_q;
    logic [4:0]                 beat_d, beat_q;
    logic [fbr_pkg::ADDR_W-1:0] addr_d, addr_q;
    logic [fbr_pkg::DATA_W-1:0] dout_d, dout_q;
    logic                       valid_d, valid_q;
    logic                       pred_d, pred_q;
    logic                       oe_d, oe_q;
    logic                       rdy_d, rdy_q;
    logic [fbr_pkg::ADDR_W-1:0] seq_next;
    logic                       seq_cross;
    logic                       beat_go;
    logic                       latch_go;
    logic                       rdy_act;
    logic [3:0]                 wait_code;
    logic                       pol_bit;
    logic                       timing_bit;
    logic [2:0]                 next_bank;

    fbr_pin_sync u_sync (
        .sys_clk                (sys_clk),
        .resetn                 (resetn),
        .bus_clk                (bus_clk),
        .ce_n                   (ce_n),
        .address_latch_strobe_n (address_latch_strobe_n),
        .addr_hi                (addr_hi),
        .adq_in                 (adq_in),
        .pins                   (pins)
    );

    fbr_addr_seq u_seq (
        .mode       (mode_q),
        .addr       (addr_q),
        .next_addr  (seq_next),
        .bank_cross (seq_cross)
    );

    // config fields and the bank of the next address
    assign wait_code  = cfg_q[fbr_pkg::CFG_WAIT_MSB:fbr_pkg::CFG_WAIT_LSB];
    assign pol_bit    = cfg_q[fbr_pkg::CFG_POL_BIT];
    assign timing_bit = cfg_q[fbr_pkg::CFG_TIMING_BIT];
    assign next_bank  = seq_next[fbr_pkg::BANK_MSB:fbr_pkg::BANK_LSB];

    // config word: only a set command or hardware reset changes it, command reset does not
    always_comb begin
        cfg_d   = cfg_wr_en ? cfg_wr_data : cfg_q; // [R10] [R11]
        drive_d = cfg_d[fbr_pkg::CFG_DRIVE_BIT]; // [R16]
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q   <= fbr_pkg::CFG_RESET; // [R10]
            drive_q <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            drive_q <= drive_d;
        end
    end

    // start and beat conditions on a link clock rise
    assign latch_go = pins.bus_clk_rise && !pins.address_latch_strobe_n;
    assign beat_go  = pins.bus_clk_rise && pins.address_latch_strobe_n &&
        ((state_q == fbr_pkg::ST_BURST) ||
         (state_q == fbr_pkg::ST_WAIT && cnt_q == 4'h1));

    // burst engine next state
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        cnt_d   = cnt_q;
        beat_d  = beat_q;
        addr_d  = addr_q;
        dout_d  = dout_q;
        valid_d = valid_q;
        pred_d  = pred_q;
        if (pins.ce_n || cmd_reset) begin
            state_d = fbr_pkg::ST_IDLE; // [R01] [R07]
            valid_d = 1'b0;
            pred_d  = 1'b0;
        end else if (pins.bus_clk_rise) begin
            valid_d = 1'b0;
            if (latch_go) begin
                if (!cfg_q[fbr_pkg::CFG_READ_MODE_BIT]) begin // [R18]
                    state_d = fbr_pkg::ST_WAIT;
                    cnt_d   = fbr_pkg::fbr_latency_edges(wait_code); // [R13]
                    addr_d  = pins.addr; // [R05]
                    beat_d  = 5'h00;
                    mode_d  = fbr_pkg::fbr_decode_mode(
                        cfg_q[fbr_pkg::CFG_LEN_MSB:fbr_pkg::CFG_LEN_LSB]);
                end else begin
                    state_d = fbr_pkg::ST_IDLE;
                end
            end else if (beat_go) begin
                // present the word and step the address
                dout_d  = mem_rdata; // [R19]
                valid_d = 1'b1;
                addr_d  = seq_next; // [R19]
                state_d = fbr_pkg::ST_BURST; // [R06] [R08]
                if (mode_q != fbr_pkg::MODE_CONT) begin
                    beat_d = beat_q + 5'h01;
                    if (beat_d == fbr_pkg::fbr_beat_limit(mode_q)) begin
                        state_d = fbr_pkg::ST_HOLD; // [R05] [R07]
                        addr_d  = addr_q;
                    end
                end else if (seq_cross) begin
                    if (bank_busy[next_bank]) begin
                        state_d = fbr_pkg::ST_HALT; // [R03]
                    end else if (fbr_pkg::BANK_CROSS_WS != 4'h0) begin
                        state_d = fbr_pkg::ST_CROSS; // [R02]
                        cnt_d   = fbr_pkg::BANK_CROSS_WS;
                    end
                end
            end else begin
                unique case (state_q)
                    fbr_pkg::ST_WAIT: begin
                        cnt_d = cnt_q - 4'h1;
                    end
                    fbr_pkg::ST_CROSS: begin
                        if (cnt_q == 4'h1) begin
                            state_d = fbr_pkg::ST_BURST; // [R02]
                        end else begin
                            cnt_d = cnt_q - 4'h1;
                        end
                    end
                    fbr_pkg::ST_IDLE, fbr_pkg::ST_BURST,
                    fbr_pkg::ST_HOLD, fbr_pkg::ST_HALT: begin
                        state_d = state_q; // held word stays put
                    end
                    default: begin
                        state_d = fbr_pkg::ST_IDLE;
                    end
                endcase
            end
            pred_d = (state_d == fbr_pkg::ST_BURST) ||
                     (state_d == fbr_pkg::ST_WAIT && cnt_d == 4'h1);
        end
        // bus driven from the first word until the burst ends
        oe_d = (state_d != fbr_pkg::ST_IDLE) &&
               (state_d != fbr_pkg::ST_WAIT); // [R03]
        rdy_act = timing_bit ? valid_d : pred_d; // [R15]
        rdy_d   = pol_bit ? rdy_act : ~rdy_act; // [R14]
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= fbr_pkg::ST_IDLE;
            mode_q  <= fbr_pkg::MODE_CONT;
            cnt_q   <= 4'h0;
            beat_q  <= 5'h00;
            addr_q  <= 24'h000000;
            dout_q  <= 16'h0000;
            valid_q <= 1'b0;
            pred_q  <= 1'b0;
            oe_q    <= 1'b0;
            rdy_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
            cnt_q   <= cnt_d;
            beat_q  <= beat_d;
            addr_q  <= addr_d;
            dout_q  <= dout_d;
            valid_q <= valid_d;
            pred_q  <= pred_d;
            oe_q    <= oe_d;
            rdy_q   <= rdy_d;
        end
    end

    // outputs straight from flops
    assign adq_out     = dout_q;
    assign adq_oe      = oe_q;
    assign rdy         = rdy_q;
    assign half_drive  = drive_q;
    assign cfg_rd_data = cfg_q; // [R12]
    assign mem_addr    = addr_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic [20:0] grp8;
    logic [19:0] grp16;
    assign grp8  = addr_q[23:3];
    assign grp16 = addr_q[23:4];

    sequence s_latch;
        latch_go && !pins.ce_n && !cmd_reset &&
        !cfg_q[fbr_pkg::CFG_READ_MODE_BIT];
    endsequence

    sequence s_quiet_edge;
        pins.bus_clk_rise && pins.address_latch_strobe_n &&
        !pins.ce_n && !cmd_reset;
    endsequence

    chk_cfg_reset_value: assert property ( // [R10]
        $rose(resetn) |-> cfg_q == fbr_pkg::CFG_RESET)
        else $error("config word not at default after reset");

    chk_cmd_reset_keeps: assert property ( // [R10]
        cmd_reset && !cfg_wr_en |=> cfg_q == $past(cfg_q))
        else $error("command reset changed the config word");

    chk_initial_latency: assert property ( // [R13]
        s_latch |=> state_q == fbr_pkg::ST_WAIT &&
            cnt_q == fbr_pkg::fbr_latency_edges($past(wait_code)))
        else $error("initial latency count wrong");

    chk_ce_abort_idle: assert property ( // [R01]
        pins.ce_n |=> state_q == fbr_pkg::ST_IDLE && !adq_oe)
        else $error("burst not ended by chip select");

    chk_wrap8_group: assert property ( // [R04]
        beat_go && mode_q == fbr_pkg::MODE_WRAP8 && !pins.ce_n &&
        !cmd_reset |=> grp8 == $past(grp8))
        else $error("8-word burst left its group");

    chk_wrap16_group: assert property ( // [R04]
        beat_go && mode_q == fbr_pkg::MODE_WRAP16 && !pins.ce_n &&
        !cmd_reset |=> grp16 == $past(grp16))
        else $error("16-word burst left its group");

    chk_beat_limit: assert property ( // [R05]
        mode_q != fbr_pkg::MODE_CONT |->
            beat_q <= fbr_pkg::fbr_beat_limit(mode_q))
        else $error("wrap burst gave too many words");

    chk_wrap8_no_ws: assert property ( // [R06]
        s_quiet_edge ##0 state_q == fbr_pkg::ST_BURST &&
        mode_q == fbr_pkg::MODE_WRAP8 && beat_q < 5'h07 |=>
            state_q == fbr_pkg::ST_BURST && valid_q)
        else $error("wait state inside 8-word burst");

    chk_hold_stable: assert property ( // [R07]
        state_q == fbr_pkg::ST_HOLD ##1 state_q == fbr_pkg::ST_HOLD |->
            $stable(adq_out) && adq_oe)
        else $error("held final word changed");

    // word before the halt may still show ready until the next rise
    chk_halt_ready_off: assert property ( // [R03]
        s_quiet_edge ##0 state_q == fbr_pkg::ST_HALT
        |=> rdy == !$past(pol_bit) && adq_oe)
        else $error("halted burst shows ready or releases bus");

    chk_ready_early: assert property ( // [R15]
        s_quiet_edge ##0 state_q == fbr_pkg::ST_WAIT && cnt_q == 4'h2 &&
        !timing_bit && !cfg_wr_en |=> rdy == pol_bit && !valid_q)
        else $error("early ready not one edge before data");

    chk_ready_polarity: assert property ( // [R14]
        valid_q && timing_bit && $stable(cfg_q) |-> rdy == pol_bit)
        else $error("ready level does not match polarity");
endmodule : fbr_burst_read

// ===== fbr_pkg.sv
// constants, types and decode functions for the flash burst read block
package fbr_pkg;

    // widths of the link and the array address
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int HI_W      = 8;
    localparam int CFG_W     = 16;
    localparam int NUM_BANKS = 8;
    localparam int BANK_MSB  = 23;
    localparam int BANK_LSB  = 21;
    localparam int SYNC_W    = 3 + HI_W + DATA_W;

    // configuration word default and field positions
    localparam logic [CFG_W-1:0] CFG_RESET = 16'hDF48;
    localparam int CFG_READ_MODE_BIT = 15;
    localparam int CFG_WAIT_MSB      = 14;
    localparam int CFG_WAIT_LSB      = 11;
    localparam int CFG_POL_BIT       = 10;
    localparam int CFG_TIMING_BIT    = 8;
    localparam int CFG_DRIVE_BIT     = 7;
    localparam int CFG_LEN_MSB       = 2;
    localparam int CFG_LEN_LSB       = 0;

    // wait-state codes and latency offset
    localparam logic [3:0] WAIT_CODE_MIN  = 4'h1;
    localparam logic [3:0] WAIT_CODE_MAX  = 4'hB;
    localparam logic [3:0] LATENCY_OFFSET = 4'h2;
    localparam logic [3:0] LATENCY_MAX    = 4'hD;

    // burst length codes and beat counts
    localparam logic [2:0] LEN_CONT     = 3'h0;
    localparam logic [2:0] LEN_WRAP8    = 3'h2;
    localparam logic [2:0] LEN_WRAP16   = 3'h3;
    localparam logic [4:0] BEATS_WRAP8  = 5'h08;
    localparam logic [4:0] BEATS_WRAP16 = 5'h10;

    // empty edges when a continuous burst enters an idle bank
    localparam logic [3:0] BANK_CROSS_WS = 4'h1;

    // synchroniser reset: link clock low, strobes high, bus zero
    localparam logic [SYNC_W-1:0] SYNC_RESET = {3'h3, 24'h000000};

    typedef enum logic [1:0] {
        MODE_CONT   = 2'b00,
        MODE_WRAP8  = 2'b01,
        MODE_WRAP16 = 2'b10
    } fbr_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_BURST = 3'b010,
        ST_CROSS = 3'b011,
        ST_HOLD  = 3'b100,
        ST_HALT  = 3'b101
    } fbr_state_type;

    // burst length code to mode, unassigned codes run continuous
    function automatic fbr_mode_type fbr_decode_mode(
        input logic [2:0] code
    );
        fbr_mode_type m;
        m = MODE_CONT;
        if (code == LEN_WRAP8) begin // [R20]
            m = MODE_WRAP8;
        end else if (code == LEN_WRAP16) begin // [R17]
            m = MODE_WRAP16;
        end
        return m;
    endfunction : fbr_decode_mode

    // wait code to link edges from latch to first data
    function automatic logic [3:0] fbr_latency_edges(
        input logic [3:0] code
    );
        logic [3:0] n;
        n = LATENCY_MAX;
        if (code >= WAIT_CODE_MIN && code <= WAIT_CODE_MAX) begin
            n = code + LATENCY_OFFSET; // [R13]
        end
        return n;
    endfunction : fbr_latency_edges

    // words delivered by a wrap burst
    function automatic logic [4:0] fbr_beat_limit(input fbr_mode_type m);
        return (m == MODE_WRAP16) ? BEATS_WRAP16 : BEATS_WRAP8;
    endfunction : fbr_beat_limit

endpackage : fbr_pkg

// ===== fbr_pins_if.sv
// sampled link pins passed from the synchroniser to the burst engine
`timescale 1ns/10ps
interface fbr_pins_if;
    logic                      bus_clk_rise;
    logic                      ce_n;
    logic                      address_latch_strobe_n;
    logic [fbr_pkg::ADDR_W-1:0] addr;

    modport src (
        output bus_clk_rise,
        output ce_n,
        output address_latch_strobe_n,
        output addr
    );
    modport dst (
        input bus_clk_rise,
        input ce_n,
        input address_latch_strobe_n,
        input addr
    );
endinterface : fbr_pins_if

// ===== fbr_pin_sync.sv
// two-stage synchronisers and link clock edge finder
`timescale 1ns/10ps
module fbr_pin_sync (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // raw pins
    input  wire logic                       bus_clk,
    input  wire logic                       ce_n,
    input  wire logic                       address_latch_strobe_n,
    input  wire logic [fbr_pkg::HI_W-1:0]   addr_hi,
    input  wire logic [fbr_pkg::DATA_W-1:0] adq_in,
    // sampled view
    fbr_pins_if.src                         pins
);
    logic [fbr_pkg::SYNC_W-1:0] raw;
    logic [fbr_pkg::SYNC_W-1:0] meta_q;
    logic [fbr_pkg::SYNC_W-1:0] sync_q;
    logic                       clk_prev_d;
    logic                       clk_prev_q;

    assign raw = {bus_clk, ce_n, address_latch_strobe_n, addr_hi, adq_in};

    // one two-flop chain per pin bit
    genvar i;
    generate
        for (i = 0; i < fbr_pkg::SYNC_W; i++) begin : g_sync
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_q[i] <= fbr_pkg::SYNC_RESET[i];
                    sync_q[i] <= fbr_pkg::SYNC_RESET[i];
                end else begin
                    meta_q[i] <= raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    // previous link clock level, read from the second stage only
    always_comb begin
        clk_prev_d = sync_q[fbr_pkg::SYNC_W-1];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // sampled outputs
    assign pins.bus_clk_rise = sync_q[fbr_pkg::SYNC_W-1] & ~clk_prev_q;
    assign pins.ce_n                   = sync_q[fbr_pkg::SYNC_W-2];
    assign pins.address_latch_strobe_n = sync_q[fbr_pkg::SYNC_W-3];
    assign pins.addr = sync_q[fbr_pkg::ADDR_W-1:0];
endmodule : fbr_pin_sync

// ===== fbr_addr_seq.sv
// next burst word address for each burst mode
`timescale 1ns/10ps
module fbr_addr_seq (
    // current position
    input  wire fbr_pkg::fbr_mode_type       mode,
    input  wire logic [fbr_pkg::ADDR_W-1:0]  addr,
    // next position
    output logic      [fbr_pkg::ADDR_W-1:0]  next_addr,
    output logic                             bank_cross
);
    // wrap modes only turn the low bits, so no 128-word crossing
    always_comb begin
        next_addr = addr;
        unique case (mode)
            fbr_pkg::MODE_CONT: begin
                next_addr = addr + 24'h000001; // [R01]
            end
            fbr_pkg::MODE_WRAP8: begin
                next_addr = {addr[23:3], addr[2:0] + 3'h1}; // [R04] [R05]
            end
            fbr_pkg::MODE_WRAP16: begin
                next_addr = {addr[23:4], addr[3:0] + 4'h1}; // [R04] [R09]
            end
            default: begin
                next_addr = addr;
            end
        endcase
        bank_cross = (mode == fbr_pkg::MODE_CONT) &&
            (next_addr[fbr_pkg::BANK_MSB:fbr_pkg::BANK_LSB] !=
             addr[fbr_pkg::BANK_MSB:fbr_pkg::BANK_LSB]);
    end
endmodule : fbr_addr_seq

// ===== fbr_host_model.sv
// host memory controller model that frames bursts on the link
`timescale 1ns/10ps
module fbr_host_model (
    // link pins driven by the host
    output logic             bus_clk,
    output logic             ce_n,
    output logic             address_latch_strobe_n,
    output logic [7:0]       addr_hi,
    output logic [15:0]      adq_in,
    // device answers
    input  wire logic [15:0] adq_out,
    input  wire logic        adq_oe,
    input  wire logic        rdy
);
    logic [15:0] d_seen [64];
    logic        r_seen [64];
    logic        oe_seen [64];

    // idle link: clock parked low outside frames
    initial begin
        bus_clk = 1'b0;
        ce_n = 1'b1;
        address_latch_strobe_n = 1'b1;
        {addr_hi, adq_in} = 24'h000000;
    end

    // one frame: latch at rise 0, sample each rise at its fall
    task automatic run(input logic [23:0] a, input int n);
        #1; // step off the system clock edge
        ce_n = 1'b0;
        address_latch_strobe_n = 1'b0;
        {addr_hi, adq_in} = a;
        #62.5;
        for (int k = 0; k < n; k++) begin
            bus_clk = 1'b1;
            #62.5;
            bus_clk = 1'b0;
            d_seen[k] = adq_out;
            r_seen[k] = rdy; // waits are seen through ready
            oe_seen[k] = adq_oe;
            address_latch_strobe_n = 1'b1;
            adq_in = ~adq_in; // released bus keeps toggling
            #62.5;
        end
        ce_n = 1'b1;
    endtask : run
endmodule : fbr_host_model

// ===== tb_top.sv
// self-checking bench for the burst read engine
`timescale 1ns/10ps
module tb_top;
    logic        sys_clk, resetn, bus_clk, ce_n, address_latch_strobe_n;
    logic        adq_oe, rdy, half_drive, cfg_wr_en, cmd_reset;
    logic [7:0]  addr_hi, bank_busy;
    logic [15:0] adq_in, adq_out, cfg_wr_data, cfg_rd_data, mem_rdata;
    logic [23:0] mem_addr;
    logic [15:0] cfg;
    logic [2:0]  lc [5] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h7};
    int          error_cnt, tests_run, cyc;

    fbr_burst_read fbr_burst_read_i (.sys_clk(sys_clk), .resetn(resetn),
        .bus_clk(bus_clk), .ce_n(ce_n),
        .address_latch_strobe_n(address_latch_strobe_n), .addr_hi(addr_hi),
        .adq_in(adq_in), .adq_out(adq_out), .adq_oe(adq_oe), .rdy(rdy),
        .half_drive(half_drive), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_data(cfg_wr_data), .cmd_reset(cmd_reset),
        .cfg_rd_data(cfg_rd_data), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .bank_busy(bank_busy));
    fbr_host_model fbr_host_model_i (.bus_clk(bus_clk), .ce_n(ce_n),
        .address_latch_strobe_n(address_latch_strobe_n), .addr_hi(addr_hi),
        .adq_in(adq_in), .adq_out(adq_out), .adq_oe(adq_oe), .rdy(rdy));

    // array contents are a fixed scramble of the word address
    function automatic logic [15:0] memf(input logic [23:0] a);
        return a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h5A3C;
    endfunction : memf
    assign mem_rdata = memf(mem_addr);

    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // write config, run one frame, predict each rise and compare
    task automatic burst(input logic [15:0] c, input logic [23:0] s,
                         input logic [7:0] busy);
        logic [23:0] a, nx;
        logic [15:0] last;
        logic        de [65];
        int          lat, lim, n, gap, hold, act;
        lim = (c[2:0] == 3'h2) ? 8 : (c[2:0] == 3'h3) ? 16 : 0;
        lat = (c[14:11] >= 4'h1 && c[14:11] <= 4'hB) ? c[14:11] + 2 : 13;
        n = lat + ((lim == 0) ? 10 : lim) + 3;
        @(posedge sys_clk);
        cfg_wr_en <= 1'b1;
        cfg_wr_data <= c;
        bank_busy <= busy;
        @(posedge sys_clk);
        cfg_wr_en <= 1'b0;
        @(posedge sys_clk);
        check(cfg_rd_data, c);
        check(16'(half_drive), 16'(c[7]));
        fbr_host_model_i.run(s, n);
        a = s;
        gap = 0;
        hold = 0;
        last = 16'h0000;
        act = 0;
        for (int k = 0; k <= n; k++) begin
            de[k] = 1'b0;
            if (k >= lat && k < n && !c[15] && hold == 0) begin
                if (gap == 1) begin
                    gap = 0;
                end else begin
                    de[k] = 1'b1;
                    last = memf(a);
                    act++;
                    nx = (lim == 0) ? a + 24'h000001 : (lim == 8) ?
                        {a[23:3], a[2:0] + 3'h1} : {a[23:4], a[3:0] + 4'h1};
                    if (lim == 0 && nx[23:21] != a[23:21]) begin
                        hold = busy[nx[23:21]] ? 2 : 0;
                        gap = busy[nx[23:21]] ? 0 : 1;
                    end
                    if (lim != 0 && act == lim) begin
                        hold = 1;
                    end
                    a = nx;
                end
            end
            if (k < n && k >= lat && !c[15] && hold != 2) begin
                check(fbr_host_model_i.d_seen[k], last);
            end
            if (k < n) begin
                check(16'(fbr_host_model_i.oe_seen[k]),
                      16'(k >= lat && !c[15]));
            end
        end
        for (int k = 0; k < n - 1; k++) begin
            check(16'(fbr_host_model_i.r_seen[k]), 16'((c[8] ? de[k] :
                  de[k + 1]) ^ !c[10]));
        end
        repeat (6) @(posedge sys_clk);
        check(16'(adq_oe), 16'h0000);
        $display("burst done start %h cfg %h", s, c);
    endtask : burst

    // main sequence
    initial begin
        resetn = 1'b0;
        cfg_wr_en = 1'b0;
        cfg_wr_data = 16'h0000;
        cmd_reset = 1'b0;
        bank_busy = 8'h00;
        void'($urandom(91));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        check(cfg_rd_data, 16'hDF48);
        check({14'h0, half_drive, adq_oe}, 16'h0000);
        $display("reset test done");
        burst(16'h0D02, 24'h00001E, 8'h00);
        burst(16'h0D00, 24'h1FFFFE, 8'h02);
        burst(16'h0C00, 24'h1FFFFE, 8'h00);
        burst(16'h1500, 24'hFFFFFE, 8'h00);
        burst(16'h0D03, 24'h00017B, 8'h00);
        for (int i = 0; i < 30; i++) begin
            cfg = {i % 6 == 5, 4'($urandom_range(0, 12)), 4'($urandom),
                   4'($urandom), lc[i % 5]};
            burst(cfg, 24'($urandom), 8'($urandom));
        end
        @(posedge sys_clk);
        cmd_reset <= 1'b1;
        @(posedge sys_clk);
        cmd_reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(cfg_rd_data, cfg);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(cfg_rd_data, 16'hDF48);
        resetn <= 1'b1;
        $display("command and hardware reset test done");
        end_sim();
    end
endmodule : tb_top
